// [core/sst_pkg.sv]
package sst_pkg;
  // machine word sizes
  localparam int DATA_W = 8;   // data memory and accumulator width
  localparam int CODE_W = 14;  // program word width
  localparam int ADDR_W = 10;  // program memory address width
  localparam int TPTR_W = 8;   // table pointer width, low address bits in a page
  localparam int DMA_W = 7;    // data memory address width
  localparam int NIB_W = 4;    // nibble width
  // flag bit positions inside the flag byte
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_PDF = 4;
  localparam int FLAG_TO = 5;
  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] TBH_RST = 8'h00;
  // cycle counts of a skip-type instruction
  localparam int SKIP_CYCLES = 2;
  localparam int NOSKIP_CYCLES = 1;

  // operations decoded upstream and handed to this block
  typedef enum logic [3:0] {
    SST_OP_NONE,
    SST_OP_NSWAP,    // nibble_swap_to_accumulator
    SST_OP_SKZ,      // skip_when_zero
    SST_OP_CPSKZ,    // copy_and_skip_when_zero
    SST_OP_BITSKZ,   // bit test, skip when clear
    SST_OP_TRD_CUR,  // table_read_current_page
    SST_OP_TRD_LST,  // table_read_last_page
    SST_OP_XOR_A,    // xor to accumulator
    SST_OP_XOR_M,    // exclusive_or_to_memory
    SST_OP_XOR_I     // xor immediate
  } sst_op_t;

  // executor sequencing
  typedef enum logic [1:0] {
    SST_IDLE,
    SST_TBL_WAIT,
    SST_DUMMY
  } sst_state_t;
endpackage : sst_pkg

// [core/sst_tbl_addr.sv]
`timescale 1ns/1ps
`default_nettype none
// forms the program memory address of a table read
module sst_tbl_addr #(
  parameter int ADDR_W = 10,
  parameter int TPTR_W = 8
) (
  input wire logic i_last_page,
  input wire logic [ADDR_W-1:0] i_pc,
  input wire logic [TPTR_W-1:0] i_table_pointer,
  output logic [ADDR_W-1:0] o_addr
);
  localparam int PAGE_W = ADDR_W - TPTR_W;  // page bits above the pointer
  logic [PAGE_W-1:0] page;  // selected page number

  // current page from pc upper bits, last page is all ones
  always_comb begin
    page = i_last_page ? {PAGE_W{1'b1}} : i_pc[ADDR_W-1:TPTR_W];
    o_addr = {page, i_table_pointer};
  end
endmodule : sst_tbl_addr
`default_nettype wire

// [core/sst_exec.sv]
// Functional notes
// - swap nibbles of byte into accumulator
// - byte zero skips, costs two cycles
// - copy byte to accumulator, skip if zero
// - selected bit clear skips next instruction
// - current-page table read to memory, high
// - last-page table read to memory, high
// - xor byte into accumulator, zero flag
// - xor result written back to memory
// - xor immediate into accumulator, zero flag
`timescale 1ns/1ps
`default_nettype none
module sst_exec #(
  parameter int DATA_W = sst_pkg::DATA_W,
  parameter int CODE_W = sst_pkg::CODE_W,
  parameter int ADDR_W = sst_pkg::ADDR_W,
  parameter int TPTR_W = sst_pkg::TPTR_W,
  parameter int DMA_W = sst_pkg::DMA_W
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_issue,                     // one-cycle pulse: execute i_op
  input wire sst_pkg::sst_op_t i_op,            // decoded operation
  input wire logic [DMA_W-1:0] i_mem_addr,      // operand address [m]
  input wire logic [DATA_W-1:0] i_mem_rdata,    // operand byte read at [m]
  input wire logic [2:0] i_bit_sel,             // bit index for bit test
  input wire logic [DATA_W-1:0] i_imm,          // immediate constant
  input wire logic [ADDR_W-1:0] i_pc,           // program counter
  input wire logic [TPTR_W-1:0] i_table_pointer,
  input wire logic [CODE_W-1:0] i_rom_rdata,    // program word, sampled at the end of the cycle o_rom_req is high
  output logic o_busy,                          // block holds the pipeline
  output logic o_flush,                         // discard prefetched instruction
  output logic o_done,                          // instruction finished
  output logic o_rom_req,
  output logic [ADDR_W-1:0] o_rom_addr,
  output logic o_mem_we,
  output logic [DMA_W-1:0] o_mem_waddr,
  output logic [DATA_W-1:0] o_mem_wdata,
  output logic [DATA_W-1:0] o_acc,
  output logic [DATA_W-1:0] o_flags,            // TO PDF OV Z AC C
  output logic [DATA_W-1:0] o_table_high_byte
);
  localparam int HI_W = CODE_W - DATA_W;  // width of the table high part

  // state registers
  sst_pkg::sst_state_t state_ff, nxt_state;
  logic [DATA_W-1:0] acc_ff, nxt_acc;          // accumulator
  logic [DATA_W-1:0] flags_ff, nxt_flags;      // status flags
  logic [DATA_W-1:0] tbh_ff, nxt_tbh;          // table_high_byte
  logic [DMA_W-1:0] tdst_ff, nxt_tdst;         // table read destination
  logic busy_ff, nxt_busy;
  logic flush_ff, nxt_flush;
  logic done_ff, nxt_done;
  logic rom_req_ff, nxt_rom_req;
  logic [ADDR_W-1:0] rom_addr_ff, nxt_rom_addr;
  logic mem_we_ff, nxt_mem_we;
  logic [DMA_W-1:0] mem_waddr_ff, nxt_mem_waddr;
  logic [DATA_W-1:0] mem_wdata_ff, nxt_mem_wdata;
  logic [ADDR_W-1:0] tbl_addr;                 // computed table address

  // zero test used by both zero-skip paths and every xor path
  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    is_zero = (v == '0);
  endfunction : is_zero

  // table address: page select plus pointer
  sst_tbl_addr #(
    .ADDR_W(ADDR_W),
    .TPTR_W(TPTR_W)
  ) u_tbl_addr (
    .i_last_page(i_op == sst_pkg::SST_OP_TRD_LST),
    .i_pc(i_pc),
    .i_table_pointer(i_table_pointer),
    .o_addr(tbl_addr)
  );

  // next-state computation; only the zero flag is ever touched
  always_comb begin
    logic [DATA_W-1:0] x;
    x = acc_ff ^ i_mem_rdata;
    nxt_state = state_ff;
    nxt_acc = acc_ff;
    nxt_flags = flags_ff;
    nxt_tbh = tbh_ff;
    nxt_tdst = tdst_ff;
    nxt_busy = 1'b0;
    nxt_flush = 1'b0;
    nxt_done = 1'b0;
    nxt_rom_req = 1'b0;
    nxt_rom_addr = rom_addr_ff;
    nxt_mem_we = 1'b0;
    nxt_mem_waddr = mem_waddr_ff;
    nxt_mem_wdata = mem_wdata_ff;
    unique case (state_ff)
      sst_pkg::SST_IDLE: begin
        if (i_issue) begin
          nxt_done = 1'b1;
          unique case (i_op)
            sst_pkg::SST_OP_NSWAP: begin
              // source byte untouched, flags untouched
              nxt_acc = {i_mem_rdata[3:0], i_mem_rdata[7:4]};
            end
            sst_pkg::SST_OP_SKZ: begin
              if (is_zero(i_mem_rdata)) begin
                nxt_flush = 1'b1;
                nxt_busy = 1'b1;
                nxt_done = 1'b0;
                nxt_state = sst_pkg::SST_DUMMY;
              end
            end
            sst_pkg::SST_OP_CPSKZ: begin
              nxt_acc = i_mem_rdata;
              if (is_zero(i_mem_rdata)) begin
                nxt_flush = 1'b1;
                nxt_busy = 1'b1;
                nxt_done = 1'b0;
                nxt_state = sst_pkg::SST_DUMMY;
              end
            end
            sst_pkg::SST_OP_BITSKZ: begin
              if (!i_mem_rdata[i_bit_sel]) begin
                nxt_flush = 1'b1;
                nxt_busy = 1'b1;
                nxt_done = 1'b0;
                nxt_state = sst_pkg::SST_DUMMY;
              end
            end
            sst_pkg::SST_OP_TRD_CUR,
            sst_pkg::SST_OP_TRD_LST: begin
              // rom answers a cycle later, so hold the pipeline meanwhile
              nxt_rom_req = 1'b1;
              nxt_rom_addr = tbl_addr;
              nxt_tdst = i_mem_addr;
              nxt_busy = 1'b1;
              nxt_done = 1'b0;
              nxt_state = sst_pkg::SST_TBL_WAIT;
            end
            sst_pkg::SST_OP_XOR_A: begin
              nxt_acc = x;
              nxt_flags[sst_pkg::FLAG_Z] = is_zero(x);
            end
            sst_pkg::SST_OP_XOR_M: begin
              nxt_mem_we = 1'b1;
              nxt_mem_waddr = i_mem_addr;
              nxt_mem_wdata = x;
              nxt_flags[sst_pkg::FLAG_Z] = is_zero(x);
            end
            sst_pkg::SST_OP_XOR_I: begin
              nxt_acc = acc_ff ^ i_imm;
              nxt_flags[sst_pkg::FLAG_Z] = is_zero(acc_ff ^ i_imm);
            end
            default: begin
              // not ours: nothing to do, no done pulse
              nxt_done = 1'b0;
            end
          endcase
        end
      end
      sst_pkg::SST_TBL_WAIT: begin
        // low byte to memory, high part to table_high_byte
        nxt_mem_we = 1'b1;
        nxt_mem_waddr = tdst_ff;
        nxt_mem_wdata = i_rom_rdata[DATA_W-1:0];
        nxt_tbh = {{(DATA_W-HI_W){1'b0}}, i_rom_rdata[CODE_W-1:DATA_W]};
        nxt_done = 1'b1;
        nxt_state = sst_pkg::SST_IDLE;
      end
      sst_pkg::SST_DUMMY: begin
        // dummy cycle replacing the discarded instruction
        nxt_done = 1'b1;
        nxt_state = sst_pkg::SST_IDLE;
      end
      default: begin
        nxt_state = sst_pkg::SST_IDLE;
      end
    endcase
  end

  // register stage, synchronous reset
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_ff <= sst_pkg::SST_IDLE;
      acc_ff <= sst_pkg::ACC_RST;
      flags_ff <= sst_pkg::FLAGS_RST;
      tbh_ff <= sst_pkg::TBH_RST;
      tdst_ff <= '0;
      busy_ff <= 1'b0;
      flush_ff <= 1'b0;
      done_ff <= 1'b0;
      rom_req_ff <= 1'b0;
      rom_addr_ff <= '0;
      mem_we_ff <= 1'b0;
      mem_waddr_ff <= '0;
      mem_wdata_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      acc_ff <= nxt_acc;
      flags_ff <= nxt_flags;
      tbh_ff <= nxt_tbh;
      tdst_ff <= nxt_tdst;
      busy_ff <= nxt_busy;
      flush_ff <= nxt_flush;
      done_ff <= nxt_done;
      rom_req_ff <= nxt_rom_req;
      rom_addr_ff <= nxt_rom_addr;
      mem_we_ff <= nxt_mem_we;
      mem_waddr_ff <= nxt_mem_waddr;
      mem_wdata_ff <= nxt_mem_wdata;
    end
  end

  // outputs straight from flops
  assign o_busy = busy_ff;
  assign o_flush = flush_ff;
  assign o_done = done_ff;
  assign o_rom_req = rom_req_ff;
  assign o_rom_addr = rom_addr_ff;
  assign o_mem_we = mem_we_ff;
  assign o_mem_waddr = mem_waddr_ff;
  assign o_mem_wdata = mem_wdata_ff;
  assign o_acc = acc_ff;
  assign o_flags = flags_ff;
  assign o_table_high_byte = tbh_ff;
endmodule : sst_exec
`default_nettype wire

// [sim/sst_exec_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// port-level checker for the executor, bound onto sst_exec
module sst_exec_monitor (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_issue,
  input wire sst_pkg::sst_op_t i_op,
  input wire logic [7:0] i_mem_rdata,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] i_imm,
  input wire logic [9:0] i_pc,
  input wire logic [7:0] i_table_pointer,
  input wire logic o_busy,
  input wire logic o_flush,
  input wire logic o_done,
  input wire logic o_rom_req,
  input wire logic [9:0] o_rom_addr,
  input wire logic o_mem_we,
  input wire logic [7:0] o_mem_wdata,
  input wire logic [7:0] o_acc,
  input wire logic [7:0] o_flags
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // request taken only while idle
  wire logic go = i_issue & ~o_busy;
  // expected values formed from inputs and o_acc, sampled with the issue
  wire logic [7:0] sw = {i_mem_rdata[3:0], i_mem_rdata[7:4]};
  wire logic bclr = ~i_mem_rdata[i_bit_sel];
  wire logic [9:0] cur_a = {i_pc[9:8], i_table_pointer};
  wire logic [9:0] lst_a = {2'b11, i_table_pointer};
  wire logic [7:0] xi = o_acc ^ i_imm;
  wire logic [7:0] xm = o_acc ^ i_mem_rdata;  // register-form xor result
  property p_swap;
    go && i_op == sst_pkg::SST_OP_NSWAP |=> o_acc == $past(sw);
  endproperty
  a_swap: assert property (p_swap) else $error("swap result wrong");
  property p_skz;
    go && i_op == sst_pkg::SST_OP_SKZ && i_mem_rdata == 8'h00 |=> o_flush && o_busy ##1 o_done;
  endproperty
  a_skz: assert property (p_skz) else $error("zero skip timing wrong");
  property p_cpskz;
    go && i_op == sst_pkg::SST_OP_CPSKZ |=> o_acc == $past(i_mem_rdata) && o_flush == (o_acc == 8'h00);
  endproperty
  a_cpskz: assert property (p_cpskz) else $error("copy skip wrong");
  property p_bit;
    go && i_op == sst_pkg::SST_OP_BITSKZ |=> o_flush == $past(bclr);
  endproperty
  a_bit: assert property (p_bit) else $error("bit skip wrong");
  property p_trd_cur;
    go && i_op == sst_pkg::SST_OP_TRD_CUR |=> o_rom_req && o_rom_addr == $past(cur_a);
  endproperty
  a_trd_cur: assert property (p_trd_cur) else $error("current page address wrong");
  property p_trd_lst;
    go && i_op == sst_pkg::SST_OP_TRD_LST |=> o_rom_req && o_rom_addr == $past(lst_a);
  endproperty
  a_trd_lst: assert property (p_trd_lst) else $error("last page address wrong");
  property p_xor_i;
    go && i_op == sst_pkg::SST_OP_XOR_I |=> o_acc == $past(xi) && o_flags[2] == (o_acc == 8'h00);
  endproperty
  a_xor_i: assert property (p_xor_i) else $error("immediate xor wrong");
  // non-zero byte: one cycle, no flush, no hold
  property p_noskip;
    go && i_op == sst_pkg::SST_OP_SKZ && i_mem_rdata != 8'h00 |=> o_done && !o_flush && !o_busy;
  endproperty
  a_noskip: assert property (p_noskip) else $error("non-zero skip timing wrong");
  property p_xor_a;
    go && i_op == sst_pkg::SST_OP_XOR_A |=> o_acc == $past(xm) && o_flags[2] == (o_acc == 8'h00);
  endproperty
  a_xor_a: assert property (p_xor_a) else $error("register xor wrong");
  // memory form leaves the accumulator alone
  property p_xor_m;
    go && i_op == sst_pkg::SST_OP_XOR_M |=> o_mem_we && o_mem_wdata == $past(xm) &&
      o_flags[2] == (o_mem_wdata == 8'h00) && o_acc == $past(o_acc);
  endproperty
  a_xor_m: assert property (p_xor_m) else $error("memory xor wrong");
  // only the zero flag may ever move
  property p_flags;
    (o_flags & 8'hfb) == 8'h00;
  endproperty
  a_flags: assert property (p_flags) else $error("flag other than zero moved");
endmodule : sst_exec_monitor
bind sst_exec sst_exec_monitor sst_exec_monitor_inst (.i_clk(i_clk), .i_srst(i_srst),
  .i_issue(i_issue), .i_op(i_op), .i_mem_rdata(i_mem_rdata), .i_bit_sel(i_bit_sel),
  .i_imm(i_imm), .i_pc(i_pc), .i_table_pointer(i_table_pointer), .o_busy(o_busy),
  .o_flush(o_flush), .o_done(o_done), .o_rom_req(o_rom_req), .o_rom_addr(o_rom_addr),
  .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_acc(o_acc), .o_flags(o_flags));
`default_nettype wire

// [sim/sst_exec_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// one comparison, counted; mismatch printed at once
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module sst_exec_bench;
  logic i_clk, i_srst, i_issue, o_busy, o_flush, o_done, o_rom_req, o_mem_we;
  sst_pkg::sst_op_t i_op;
  logic [6:0] i_mem_addr, o_mem_waddr;
  logic [7:0] i_mem_rdata, i_imm, i_table_pointer, o_mem_wdata, o_acc, o_flags, o_table_high_byte;
  logic [2:0] i_bit_sel;
  logic [9:0] i_pc, o_rom_addr;
  logic [13:0] i_rom_rdata;
  int errors = 0;
  int checks_done = 0;
  sst_exec sst_exec_inst (.i_clk(i_clk), .i_srst(i_srst), .i_issue(i_issue), .i_op(i_op),
    .i_mem_addr(i_mem_addr), .i_mem_rdata(i_mem_rdata), .i_bit_sel(i_bit_sel), .i_imm(i_imm),
    .i_pc(i_pc), .i_table_pointer(i_table_pointer), .i_rom_rdata(i_rom_rdata),
    .o_busy(o_busy), .o_flush(o_flush), .o_done(o_done), .o_rom_req(o_rom_req),
    .o_rom_addr(o_rom_addr), .o_mem_we(o_mem_we), .o_mem_waddr(o_mem_waddr),
    .o_mem_wdata(o_mem_wdata), .o_acc(o_acc), .o_flags(o_flags),
    .o_table_high_byte(o_table_high_byte));
  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // issue held high; caller lowers it with idl, so back to back needs no gap
  task automatic go(input sst_pkg::sst_op_t op, input logic [7:0] d);
    i_op = op;
    i_mem_rdata = d;
    i_issue = 1'b1;
    @(posedge i_clk);
    #1;
  endtask : go
  task automatic idl;
    i_issue = 1'b0;
    @(posedge i_clk);
    #1;
  endtask : idl
  task automatic t_swap_xor;
    go(sst_pkg::SST_OP_NSWAP, 8'h3c);
    `CHK("swap acc", 8'hc3, o_acc)
    i_imm = 8'hc3;
    go(sst_pkg::SST_OP_XOR_I, 8'h00);
    `CHK("xori acc", 8'h00, o_acc)
    `CHK("xori flags", 8'h04, o_flags)
    go(sst_pkg::SST_OP_XOR_A, 8'h5a);
    `CHK("xora acc", 8'h5a, o_acc)
    `CHK("xora flags", 8'h00, o_flags)
    go(sst_pkg::SST_OP_XOR_M, 8'h0f);
    `CHK("exclusive_or_to_memory data", 8'h55, o_mem_wdata)
    `CHK("exclusive_or_to_memory we acc", {1'b1, 8'h5a}, {o_mem_we, o_acc})
    go(sst_pkg::SST_OP_XOR_M, 8'h5a);
    `CHK("exclusive_or_to_memory zero", {1'b1, 8'h00, 8'h04}, {o_mem_we, o_mem_wdata, o_flags})
    idl();
    $display("test swap_xor done");
  endtask : t_swap_xor
  task automatic t_skip;
    go(sst_pkg::SST_OP_SKZ, 8'h00);
    `CHK("skz flush busy", 2'b11, {o_flush, o_busy})
    idl();
    `CHK("skz done", 1'b1, o_done)
    go(sst_pkg::SST_OP_SKZ, 8'h01);
    `CHK("skz no skip", 2'b01, {o_flush, o_done})
    go(sst_pkg::SST_OP_CPSKZ, 8'h00);
    `CHK("cpskz acc flush", {8'h00, 1'b1}, {o_acc, o_flush})
    idl();
    i_bit_sel = 3'h7;
    go(sst_pkg::SST_OP_BITSKZ, 8'h7f);
    `CHK("bit7 flush", 1'b1, o_flush)
    idl();
    i_bit_sel = 3'h0;
    go(sst_pkg::SST_OP_BITSKZ, 8'h7f);
    `CHK("bit0 no skip", 2'b01, {o_flush, o_done})
    idl();
    `CHK("skip flags", 8'h04, o_flags)
    $display("test skip done");
  endtask : t_skip
  task automatic t_table;
    i_pc = 10'h2ab;
    i_table_pointer = 8'h34;
    go(sst_pkg::SST_OP_TRD_CUR, 8'h00);
    `CHK("cur addr", {1'b1, 10'h234}, {o_rom_req, o_rom_addr})
    i_rom_rdata = 14'h2a5c;
    idl();
    `CHK("cur write", {1'b1, 7'h12, 8'h5c}, {o_mem_we, o_mem_waddr, o_mem_wdata})
    `CHK("cur high", 8'h2a, o_table_high_byte)
    i_rom_rdata = ~i_rom_rdata;
    go(sst_pkg::SST_OP_TRD_LST, 8'h00);
    `CHK("lst addr", {1'b1, 10'h334}, {o_rom_req, o_rom_addr})
    i_rom_rdata = 14'h15a3;
    idl();
    `CHK("lst low high", {8'ha3, 8'h15}, {o_mem_wdata, o_table_high_byte})
    `CHK("table flags", 8'h04, o_flags)
    i_rom_rdata = ~i_rom_rdata;
    $display("test table done");
  endtask : t_table
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  // reset for five cycles, then the scenarios in turn
  initial begin
    {i_srst, i_issue, i_bit_sel, i_imm, i_pc, i_table_pointer, i_rom_rdata} = '0;
    i_op = sst_pkg::SST_OP_NONE;
    i_mem_addr = 7'h12;
    i_mem_rdata = 8'h00;
    i_srst = 1'b1;
    repeat (5) @(posedge i_clk);
    #1 i_srst = 1'b0;
    `CHK("reset acc flags", 16'h0000, {o_acc, o_flags})
    t_swap_xor();
    t_skip();
    t_table();
    final_report();
  end
endmodule : sst_exec_bench
`default_nettype wire
